// >>> csr_readback.sv
// charger status readback registers behind a serial two-wire target
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - limit field shows optimizer or pin limit
// - limit field counts 10 mA units
// - limit clamped 100-3300 mA, zero after reset
// - bit 7 high during input current regulation
// - bit 6 high during input voltage regulation
// - bit 5 high when host watchdog expired
// - bit 4 high when weak source found
// - bit 3 high when power is good
// - bit 2 high when second input present
// - bit 1 high when first input present
// - bit 0 high when bus power present
module csr_readback #(
  parameter logic [6:0] DEV_ADDR = csr_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic limit_valid,
  input wire logic optimizer_done,
  input wire logic [8:0] optimized_limit_value,
  input wire logic [8:0] limit_setting_pin,
  input wire csr_pkg::csr_cond_s cond,
  output logic [15:0] input_current_limit_readback,
  output logic [7:0] charger_condition_flags
);

  csr_pkg::csr_state_s r_reg;
  csr_pkg::csr_state_s r_next;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [8:0] limit_src;

  // keep a code inside the legal current window
  function automatic logic [8:0] clamp_limit(input logic [8:0] code);
    if (code < csr_pkg::ILIM_MIN_CODE) begin
      clamp_limit = csr_pkg::ILIM_MIN_CODE;
    end else if (code > csr_pkg::ILIM_MAX_CODE) begin
      clamp_limit = csr_pkg::ILIM_MAX_CODE;
    end else begin
      clamp_limit = code;
    end
  endfunction : clamp_limit

  // byte seen by the host at a pointer; high limit byte comes from the shadow
  function automatic logic [7:0] read_byte(input logic [7:0] ptr, input logic [8:0] ilim,
                                           input logic hi, input logic [7:0] flags);
    case (ptr)
      csr_pkg::OFS_ILIM_LO: read_byte = ilim[7:0];
      csr_pkg::OFS_ILIM_HI: read_byte = {7'h00, hi};
      csr_pkg::OFS_FLAGS: read_byte = flags;
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // line events from the previous sample of both wires
  assign scl_rise = scl_in & ~r_reg.scl_q;
  assign scl_fall = ~scl_in & r_reg.scl_q;
  assign start_cond = r_reg.scl_q & scl_in & r_reg.sda_q & ~sda_in;
  assign stop_cond = r_reg.scl_q & scl_in & ~r_reg.sda_q & sda_in;
  assign limit_src = optimizer_done ? optimized_limit_value : limit_setting_pin;

  // next state: register contents and link protocol
  always_comb begin
    logic [7:0] byte_val;
    byte_val = 8'h00;
    r_next = r_reg;
    r_next.scl_q = scl_in;
    r_next.sda_q = sda_in;

    // limit readback stays zero until a limit is in force
    if (limit_valid) begin
      r_next.ilim = clamp_limit(limit_src);
    end

    // condition flags follow their sources every cycle
    r_next.flags[csr_pkg::FLG_CUR_REG] = cond.current_regulation;
    r_next.flags[csr_pkg::FLG_VOLT_REG] = cond.voltage_regulation;
    r_next.flags[csr_pkg::FLG_WDOG] = cond.watchdog_expired;
    r_next.flags[csr_pkg::FLG_WEAK] = cond.weak_source;
    r_next.flags[csr_pkg::FLG_PGOOD] = cond.power_good;
    r_next.flags[csr_pkg::FLG_IN2] = cond.second_input_present;
    r_next.flags[csr_pkg::FLG_IN1] = cond.first_input_present;
    r_next.flags[csr_pkg::FLG_BUS] = cond.bus_power_present;

    // start and stop override any transfer in progress
    if (start_cond) begin
      r_next.st = csr_pkg::CSR_ADDR;
      r_next.bitcnt = 3'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      r_next.st = csr_pkg::CSR_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.st)
        csr_pkg::CSR_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        // receive address, pointer or write data, msb first
        csr_pkg::CSR_ADDR, csr_pkg::CSR_PTR, csr_pkg::CSR_WR: begin
          if (scl_rise) begin
            r_next.shreg = {r_reg.shreg[6:0], sda_in};
            r_next.bitcnt = r_reg.bitcnt + 3'h1;
            if (r_reg.bitcnt == 3'h7) begin
              r_next.phase = 1'b0;
              case (r_reg.st)
                csr_pkg::CSR_ADDR: begin
                  r_next.rw = sda_in;
                  r_next.st = (r_reg.shreg[6:0] == DEV_ADDR) ? csr_pkg::CSR_ADDR_ACK : csr_pkg::CSR_IDLE;
                end
                csr_pkg::CSR_PTR: begin
                  r_next.ptr = {r_reg.shreg[6:0], sda_in};
                  r_next.st = csr_pkg::CSR_PTR_ACK;
                end
                default: begin
                  r_next.st = csr_pkg::CSR_WR_ACK; // data byte dropped
                end
              endcase
            end
          end
        end
        // acknowledge slot: pull low after the eighth bit, release after the ninth
        csr_pkg::CSR_ADDR_ACK, csr_pkg::CSR_PTR_ACK, csr_pkg::CSR_WR_ACK: begin
          if (scl_fall) begin
            if (!r_reg.phase) begin
              r_next.sda_oe = 1'b1;
              r_next.phase = 1'b1;
            end else begin
              r_next.sda_oe = 1'b0;
              r_next.bitcnt = 3'h0;
              if (r_reg.st == csr_pkg::CSR_WR_ACK) begin
                r_next.ptr = r_reg.ptr + 8'h01;
              end
              if (r_reg.st == csr_pkg::CSR_ADDR_ACK && r_reg.rw) begin
                byte_val = read_byte(r_reg.ptr, r_reg.ilim, r_reg.hi_shadow, r_reg.flags);
                if (r_reg.ptr == csr_pkg::OFS_ILIM_LO) begin
                  r_next.hi_shadow = r_reg.ilim[8];
                end
                r_next.shreg = byte_val;
                r_next.sda_oe = ~byte_val[7];
                r_next.st = csr_pkg::CSR_RD;
              end else if (r_reg.st == csr_pkg::CSR_ADDR_ACK) begin
                r_next.st = csr_pkg::CSR_PTR;
              end else begin
                r_next.st = csr_pkg::CSR_WR;
              end
            end
          end
        end
        // send a byte, changing the line only while the clock is low
        csr_pkg::CSR_RD: begin
          if (scl_fall) begin
            r_next.bitcnt = r_reg.bitcnt + 3'h1;
            if (r_reg.bitcnt == 3'h7) begin
              r_next.sda_oe = 1'b0;
              r_next.st = csr_pkg::CSR_RD_ACK;
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.nack = 1'b1;
            end else begin
              r_next.shreg = {r_reg.shreg[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.shreg[6];
            end
          end
        end
        // host acknowledge: continue with next byte or end the read
        csr_pkg::CSR_RD_ACK: begin
          if (scl_rise) begin
            r_next.nack = sda_in;
          end else if (scl_fall) begin
            r_next.bitcnt = 3'h0;
            if (r_reg.nack) begin
              r_next.st = csr_pkg::CSR_IDLE;
            end else begin
              byte_val = read_byte(r_reg.ptr, r_reg.ilim, r_reg.hi_shadow, r_reg.flags);
              if (r_reg.ptr == csr_pkg::OFS_ILIM_LO) begin
                r_next.hi_shadow = r_reg.ilim[8];
              end
              r_next.shreg = byte_val;
              r_next.sda_oe = ~byte_val[7];
              r_next.st = csr_pkg::CSR_RD;
            end
          end
        end
        default: begin
          r_next.st = csr_pkg::CSR_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // state register; reset clears all fields except nack, scl_q and sda_q, which load one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // link idle with both wires seen high, so no false start after reset
      r_reg <= '{st: csr_pkg::CSR_IDLE,
                 bitcnt: 3'h0,
                 phase: 1'b0,
                 nack: 1'b1,
                 shreg: 8'h00,
                 ptr: 8'h00,
                 rw: 1'b0,
                 sda_oe: 1'b0,
                 scl_q: 1'b1,
                 sda_q: 1'b1,
                 ilim: csr_pkg::ILIM_RESET,
                 hi_shadow: 1'b0,
                 flags: csr_pkg::FLAGS_RESET};
    end else begin
      r_reg <= r_next;
    end
  end

  // open-drain data line and register images
  assign sda_out = 1'b0;
  assign sda_oe = r_reg.sda_oe;
  assign input_current_limit_readback = {7'h00, r_reg.ilim};
  assign charger_condition_flags = r_reg.flags;

endmodule : csr_readback

`default_nettype wire

// >>> csr_pkg.sv
// package for the charger status readback block: offsets, field layout, states
package csr_pkg;

  // byte offsets in the serial register space
  localparam logic [7:0] OFS_ILIM_LO = 8'h19;
  localparam logic [7:0] OFS_ILIM_HI = 8'h1A;
  localparam logic [7:0] OFS_FLAGS = 8'h1B;

  // target address on the serial link (arbitrary neutral value)
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2B;

  // limit field: width, clamp bounds in 10 mA units, values after reset
  localparam int ILIM_W = 9;
  localparam int ILIM_STEP_MA = 10;
  localparam int ILIM_MIN_MA = 100;
  localparam int ILIM_MAX_MA = 3300;
  localparam logic [8:0] ILIM_MIN_CODE = 9'(ILIM_MIN_MA / ILIM_STEP_MA);
  localparam logic [8:0] ILIM_MAX_CODE = 9'(ILIM_MAX_MA / ILIM_STEP_MA);
  localparam logic [8:0] ILIM_RESET = 9'h000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // condition flag bit positions
  localparam int FLG_CUR_REG = 7;
  localparam int FLG_VOLT_REG = 6;
  localparam int FLG_WDOG = 5;
  localparam int FLG_WEAK = 4;
  localparam int FLG_PGOOD = 3;
  localparam int FLG_IN2 = 2;
  localparam int FLG_IN1 = 1;
  localparam int FLG_BUS = 0;

  // serial link protocol states
  typedef enum logic [3:0] {
    CSR_IDLE = 4'h0,
    CSR_ADDR = 4'h1,
    CSR_ADDR_ACK = 4'h2,
    CSR_PTR = 4'h3,
    CSR_PTR_ACK = 4'h4,
    CSR_WR = 4'h5,
    CSR_WR_ACK = 4'h6,
    CSR_RD = 4'h7,
    CSR_RD_ACK = 4'h8
  } csr_state_e;

  // raw condition inputs from the analog side
  typedef struct packed {
    logic current_regulation;
    logic voltage_regulation;
    logic watchdog_expired;
    logic weak_source;
    logic power_good;
    logic second_input_present;
    logic first_input_present;
    logic bus_power_present;
  } csr_cond_s;

  // complete block state
  typedef struct packed {
    csr_state_e st;
    logic [2:0] bitcnt;
    logic phase;
    logic nack;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic [8:0] ilim;
    logic hi_shadow;
    logic [7:0] flags;
  } csr_state_s;

endpackage : csr_pkg

// >>> csr_readback_checker.sv
// assertions on the register images of the readback block
`timescale 1ns/100ps
`default_nettype none
module csr_readback_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic limit_valid,
  input wire logic optimizer_done,
  input wire logic [8:0] optimized_limit_value,
  input wire logic [8:0] limit_setting_pin,
  input wire csr_pkg::csr_cond_s cond,
  input wire logic [15:0] input_current_limit_readback,
  input wire logic [7:0] charger_condition_flags
);
  logic up_reg;
  logic [8:0] src;
  // selected limit source; up_reg skips the first edge after reset, where $past sees reset-time values
  assign src = optimizer_done ? optimized_limit_value : limit_setting_pin;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_reg <= 1'b0;
    end else begin
      up_reg <= 1'b1;
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);
  // a limit was offered on the previous edge
  sequence loaded;
    up_reg && $past(limit_valid);
  endsequence
  lim_pick_a: assert property (
    loaded ##0 ($past(src) >= csr_pkg::ILIM_MIN_CODE && $past(src) <= csr_pkg::ILIM_MAX_CODE)
    |-> input_current_limit_readback[8:0] == $past(src)) else $error("limit not taken from source");
  lim_low_a: assert property (
    loaded ##0 $past(src) < csr_pkg::ILIM_MIN_CODE
    |-> input_current_limit_readback[8:0] == csr_pkg::ILIM_MIN_CODE) else $error("low clamp missed");
  lim_high_a: assert property (
    loaded ##0 $past(src) > csr_pkg::ILIM_MAX_CODE
    |-> input_current_limit_readback[8:0] == csr_pkg::ILIM_MAX_CODE) else $error("high clamp missed");
  lim_hold_a: assert property (
    up_reg && !$past(limit_valid) |-> $stable(input_current_limit_readback))
    else $error("limit changed without valid");
  rsv_zero_a: assert property (
    input_current_limit_readback[15:9] == 7'h00) else $error("reserved bits set");
  reg_flags_a: assert property (
    up_reg |-> charger_condition_flags[7:6] ==
    {$past(cond.current_regulation), $past(cond.voltage_regulation)}) else $error("regulation flags wrong");
  fault_flags_a: assert property (
    up_reg |-> charger_condition_flags[5:4] ==
    {$past(cond.watchdog_expired), $past(cond.weak_source)}) else $error("fault flags wrong");
  pres_flags_a: assert property (
    up_reg |-> charger_condition_flags[3:0] == $past(cond[3:0]))
    else $error("presence flags wrong");
endmodule : csr_readback_checker
bind csr_readback csr_readback_checker u_chk (.clk, .rst, .limit_valid, .optimizer_done, .optimized_limit_value,
  .limit_setting_pin, .cond, .input_current_limit_readback, .charger_condition_flags);
`default_nettype wire

// >>> csr_host.sv
// serial host model that reads and writes the readback registers
`timescale 1ns/100ps
`default_nettype none
module csr_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_lo
);
  // both lines released while idle
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // hold a line state four clocks so the target sees every phase
  task automatic step(input logic c, input logic l);
    scl = c;
    sda_lo = l;
    repeat (4) @(negedge clk);
  endtask : step
  // nine bits msb first, each sampled at the end of its high phase
  task automatic by(input logic [8:0] w, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, !w[i]);
      step(1'b1, !w[i]);
      q[i] = sda;
    end
  endtask : by
  // start or repeated start
  task automatic start;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : start
  // n of zero writes d at pointer p, otherwise reads n bytes from p; nak collects target acknowledges
  task automatic xfer(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] d, input int n,
                      output logic [15:0] v, output logic nak);
    logic [8:0] q;
    v = 16'h0000;
    start();
    by({ad, 2'b01}, q);
    nak = q[0];
    by({p, 1'b1}, q);
    nak = nak | q[0];
    if (n == 0) begin
      by({d, 1'b1}, q);
      nak = nak | q[0];
    end else begin
      start();
      by({ad, 2'b11}, q);
      for (int k = n; k > 0; k--) begin
        nak = nak | q[0];
        by({8'hFF, k == 1}, q);
        v = {v[7:0], q[8:1]};
      end
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : xfer
endmodule : csr_host
`default_nettype wire

// >>> charger_status_readback_tb_top.sv
// self-checking bench for the charger status readback block
`timescale 1ns/100ps
`default_nettype none
module charger_status_readback_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lv = 1'b0;
  logic done = 1'b0;
  logic [8:0] opt = 9'h000;
  logic [8:0] pin = 9'h000;
  csr_pkg::csr_cond_s cond = 8'h00;
  logic scl, hlo, sda_out, sda_oe, sda, nak;
  logic [15:0] rb, v;
  logic [7:0] flags;
  int err_total = 0;
  int checks = 0;
  logic [8:0] src_t [6] = '{9'h0C8, 9'h009, 9'h00A, 9'h14B, 9'h1FF, 9'h14A};
  logic [8:0] exp_t [6] = '{9'h0C8, 9'h00A, 9'h00A, 9'h14A, 9'h14A, 9'h14A};
  // open-drain data wire with pull-up, and the clock
  assign sda = !(hlo || (sda_oe && !sda_out));
  always #12.5 clk = !clk;
  csr_readback u_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .limit_valid(lv), .optimizer_done(done), .optimized_limit_value(opt), .limit_setting_pin(pin),
    .cond(cond), .input_current_limit_readback(rb), .charger_condition_flags(flags));
  csr_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_lo(hlo));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic complete_run;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    chk(rb, 16'h0000);
    chk(16'(flags), 16'h0000);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      cond = 8'h01 << i;
      repeat (2) @(negedge clk);
      chk(16'(flags), 16'h0001 << i);
    end
    cond = 8'hA5;
    u_host.xfer(csr_pkg::DEV_ADDR_DEFAULT, csr_pkg::OFS_FLAGS, 8'h00, 1, v, nak);
    chk(v, 16'h00A5);
    lv = 1'b1;
    for (int i = 0; i < 6; i++) begin
      done = i[0];
      opt = i[0] ? src_t[i] : ~src_t[i];
      pin = i[0] ? ~src_t[i] : src_t[i];
      repeat (2) @(negedge clk);
      chk(rb, 16'(exp_t[i]));
    end
    // no valid limit: last value holds
    lv = 1'b0;
    opt = 9'h050;
    pin = 9'h050;
    repeat (3) @(negedge clk);
    chk(rb, 16'h014A);
    u_host.xfer(csr_pkg::DEV_ADDR_DEFAULT, csr_pkg::OFS_ILIM_LO, 8'h00, 2, v, nak);
    chk(v, 16'h4A01);
    chk(16'(nak), 16'h0000);
    // writes are acknowledged but change nothing
    u_host.xfer(csr_pkg::DEV_ADDR_DEFAULT, csr_pkg::OFS_ILIM_LO, 8'h00, 0, v, nak);
    chk(16'(nak), 16'h0000);
    u_host.xfer(csr_pkg::DEV_ADDR_DEFAULT, csr_pkg::OFS_FLAGS, 8'h00, 0, v, nak);
    chk(rb, 16'h014A);
    u_host.xfer(csr_pkg::DEV_ADDR_DEFAULT, csr_pkg::OFS_FLAGS, 8'h00, 1, v, nak);
    chk(v, 16'h00A5);
    u_host.xfer(csr_pkg::DEV_ADDR_DEFAULT, 8'h1C, 8'h00, 1, v, nak);
    chk(v, 16'h0000);
    // foreign address is not acknowledged
    u_host.xfer(csr_pkg::DEV_ADDR_DEFAULT ^ 7'h01, csr_pkg::OFS_FLAGS, 8'h00, 0, v, nak);
    chk(16'(nak), 16'h0001);
    complete_run();
  end
  // watchdog well beyond the expected run length
  initial begin
    #1000000;
    err_total++;
    complete_run();
  end
endmodule : charger_status_readback_tb_top
`default_nettype wire
